// *** hw/elr_event_log_mission_recorder.sv ***
// event log mission controller with host byte port on the link clock
`timescale 1ns/1ps
`include "elr_regs.svh"

module elr_event_log_mission_recorder
    import elr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        linkClk,
    input  wire logic        eventIn,
    input  wire logic [63:0] rtcNow,
    input  wire logic        rtcSecInc,
    input  wire logic        rtcMinInc,
    input  wire logic        rtcHrInc,
    input  wire logic        clearCmd,
    input  wire logic        hostReqValid,
    output logic             hostReqReady,
    input  wire elr_req_t    hostReq,
    output logic             hostRspValid,
    output logic [7:0]       hostRspData
);

    // core domain state
    elr_state_t  state_q,    state_d;
    logic        me_q,       me_d;
    logic        mip_q,      mip_d;
    logic        memClr_q,   memClr_d;
    logic        rof_q,      rof_d;
    logic        full_q,     full_d;
    logic        stopPend_q, stopPend_d;
    logic        evPend_q,   evPend_d;
    logic [1:0]  trig_q,     trig_d;
    logic [1:0]  dis_q,      dis_d;
    logic        wrap_q,     wrap_d;
    logic [63:0] stamp_q,    stamp_d;
    logic [15:0] ev0_q,      ev0_d;
    logic [23:0] count_q,    count_d;
    logic [15:0] etc_q,      etc_d;
    logic [10:0] ptr_q,      ptr_d;
    logic [7:0]  hiByte_q,   hiByte_d;
    logic [15:0] logAdr_q,   logAdr_d;
    logic [7:0]  mainPtr_q,  mainPtr_d;
    logic [7:0]  rdData_q,   rdData_d;
    logic        ackTgl_q,   ackTgl_d;
    logic        evS1_q,     evS1_d;
    logic        evS2_q,     evS2_d;
    logic        evPrev_q,   evPrev_d;
    logic        reqS1_q,    reqS1_d;
    logic        reqS2_q,    reqS2_d;
    logic        reqS3_q,    reqS3_d;

    // link domain state
    logic        lrS1_q,     lrS1_d;
    logic        lrS2_q,     lrS2_d;
    logic        busy_q,     busy_d;
    logic        reqTgl_q,   reqTgl_d;
    elr_req_t    hold_q,     hold_d;
    logic        ackS1_q,    ackS1_d;
    logic        ackS2_q,    ackS2_d;
    logic        ackS3_q,    ackS3_d;
    logic        rspV_q,     rspV_d;
    logic [7:0]  rspD_q,     rspD_d;

    logic [7:0]  logMem [0:2047];
    logic        memWe;
    logic [10:0] memAddr;
    logic [7:0]  memWd;
    logic [7:0]  rdVal;
    logic [7:0]  reqAddr;
    logic        reqNew;
    logic        evRise;
    logic        evFall;
    logic        evEdge;
    logic        tick;
    logic        settingsOk;
    logic        ctrlOk;
    logic        startNow;
    logic        consume;
    logic        clrStart;

    assign evRise     = evS2_q & ~evPrev_q;
    assign evFall     = ~evS2_q & evPrev_q;
    assign evEdge     = (trig_q[1] & evRise) | (trig_q[0] & evFall);
    assign tick       = (dis_q == `ELR_DIS_SEC  && rtcSecInc) ||
                        (dis_q == `ELR_DIS_MIN  && rtcMinInc) ||
                        (dis_q == `ELR_DIS_HOUR && rtcHrInc);
    assign settingsOk = (trig_q != `ELR_TRIG_NONE) && (dis_q != `ELR_DIS_OFF);
    assign ctrlOk     = (hold_q.data[`ELR_CTRL_TRIG_MSB:`ELR_CTRL_TRIG_LSB] != `ELR_TRIG_NONE) &&
                        (hold_q.data[`ELR_CTRL_DIS_MSB:`ELR_CTRL_DIS_LSB] != `ELR_DIS_OFF);
    // the held request stays still while the toggle crosses, so it is safe to read here
    assign reqNew     = reqS2_q ^ reqS3_q;
    assign reqAddr    = hold_q.setPtr ? hold_q.addr : mainPtr_q;
    assign hostReqReady = ~busy_q;
    assign hostRspValid = rspV_q;
    assign hostRspData  = rspD_q;

    // read mux of the main location map
    always_comb begin
        rdVal = 8'h00;
        if (reqAddr <= `ELR_A_RTC_TOP) begin
            rdVal = rtcNow[{reqAddr[2:0], 3'b000} +: 8];
        end else if (reqAddr >= `ELR_A_STAMP && reqAddr < `ELR_A_EV0_LO) begin
            rdVal = stamp_q[{reqAddr[2:0], 3'b000} +: 8];
        end else begin
            case (reqAddr)
                `ELR_A_CTRL: begin
                    rdVal[`ELR_CTRL_ARM] = me_q;
                    rdVal[`ELR_CTRL_DIS_MSB:`ELR_CTRL_DIS_LSB] = dis_q;
                    rdVal[`ELR_CTRL_WRAP] = wrap_q;
                    rdVal[`ELR_CTRL_TRIG_MSB:`ELR_CTRL_TRIG_LSB] = trig_q;
                end
                `ELR_A_STAT: begin
                    rdVal[`ELR_STAT_MEMCLR] = memClr_q;
                    rdVal[`ELR_STAT_MIP] = mip_q;
                    rdVal[`ELR_STAT_ROF] = rof_q;
                end
                `ELR_A_EV0_LO:  rdVal = ev0_q[7:0];
                `ELR_A_EV0_HI:  rdVal = ev0_q[15:8];
                `ELR_A_CNT_LO:  rdVal = count_q[7:0];
                `ELR_A_CNT_MID: rdVal = count_q[15:8];
                `ELR_A_CNT_HI:  rdVal = count_q[23:16];
                `ELR_A_ETC_LO:  rdVal = etc_q[7:0];
                `ELR_A_ETC_HI:  rdVal = etc_q[15:8];
                `ELR_A_PTR_LO:  rdVal = ptr_q[7:0];
                `ELR_A_PTR_HI:  rdVal = {5'h00, ptr_q[10:8]};
                `ELR_A_LADR_LO: rdVal = logAdr_q[7:0];
                `ELR_A_LADR_HI: rdVal = logAdr_q[15:8];
                `ELR_A_LDATA:   rdVal = logMem[logAdr_q[10:0]];
                default:        rdVal = 8'h00;
            endcase
        end
    end

    always_comb begin
        state_d    = state_q;
        me_d       = me_q;
        mip_d      = mip_q;
        memClr_d   = memClr_q;
        rof_d      = rof_q;
        full_d     = full_q;
        stopPend_d = stopPend_q;
        trig_d     = trig_q;
        dis_d      = dis_q;
        wrap_d     = wrap_q;
        stamp_d    = stamp_q;
        ev0_d      = ev0_q;
        count_d    = count_q;
        etc_d      = etc_q;
        ptr_d      = ptr_q;
        hiByte_d   = hiByte_q;
        logAdr_d   = logAdr_q;
        mainPtr_d  = mainPtr_q;
        rdData_d   = rdData_q;
        ackTgl_d   = ackTgl_q;
        evS1_d     = eventIn;
        evS2_d     = evS1_q;
        evPrev_d   = evS2_q;
        reqS1_d    = reqTgl_q;
        reqS2_d    = reqS1_q;
        reqS3_d    = reqS2_q;
        memWe      = 1'b0;
        memAddr    = ptr_q;
        memWd      = 8'h00;
        startNow   = 1'b0;
        consume    = 1'b0;
        clrStart   = 1'b0;

        // the counter keeps running through stores, so no increment is lost
        if (mip_q) begin
            etc_d = etc_q + {15'h0000, tick};
        end

        if (reqNew) begin
            mainPtr_d = reqAddr + 8'h01;
            rdData_d  = (mip_q && reqAddr > `ELR_A_USER_TOP) ? 8'h00 : rdVal;
            ackTgl_d  = ~ackTgl_q;
            if (hold_q.wr) begin
                if (mip_q) begin
                    stopPend_d = 1'b1;
                end else if (reqAddr == `ELR_A_CTRL) begin
                    trig_d = hold_q.data[`ELR_CTRL_TRIG_MSB:`ELR_CTRL_TRIG_LSB];
                    dis_d  = hold_q.data[`ELR_CTRL_DIS_MSB:`ELR_CTRL_DIS_LSB];
                    wrap_d = hold_q.data[`ELR_CTRL_WRAP];
                    if (!hold_q.data[`ELR_CTRL_ARM]) begin
                        me_d = 1'b0;
                    end else if (memClr_q && ctrlOk) begin
                        me_d = 1'b1;
                    end
                end else if (reqAddr == `ELR_A_STAT) begin
                    if (hold_q.data[`ELR_STAT_MIP] && memClr_q && settingsOk) begin
                        startNow = 1'b1;
                    end
                end else if (reqAddr == `ELR_A_LADR_LO) begin
                    logAdr_d[7:0] = hold_q.data;
                end else if (reqAddr == `ELR_A_LADR_HI) begin
                    logAdr_d[15:8] = hold_q.data;
                end
                // the data port and the log itself take no host writes
            end
        end

        if (me_q && !mip_q && evEdge) begin
            startNow = 1'b1;
        end

        unique case (state_q)
            S_IDLE: begin
                if (clearCmd && !mip_q && !me_q && !startNow) begin
                    clrStart = 1'b1;
                    state_d  = S_CLEAR;
                    ptr_d    = 11'h000;
                    memClr_d = 1'b0;
                    count_d  = 24'h000000;
                    etc_d    = 16'h0000;
                    stamp_d  = 64'h0;
                    ev0_d    = 16'h0000;
                    rof_d    = 1'b0;
                    full_d   = 1'b0;
                end else if (mip_q && evPend_q) begin
                    consume = 1'b1;
                    count_d = count_q + 24'h000001;
                    etc_d   = {15'h0000, tick};
                    if (full_q) begin
                        if (wrap_q) begin
                            stamp_d = rtcNow;
                            ev0_d   = etc_q;
                            rof_d   = 1'b1;
                            full_d  = 1'b0;
                        end
                    end else begin
                        memWe    = 1'b1;
                        memWd    = etc_q[7:0];
                        hiByte_d = etc_q[15:8];
                        ptr_d    = ptr_q + 11'h001;
                        state_d  = S_HI;
                    end
                end else if (stopPend_q) begin
                    me_d       = 1'b0;
                    mip_d      = 1'b0;
                    stopPend_d = 1'b0;
                end
            end
            S_HI: begin
                memWe   = 1'b1;
                memWd   = hiByte_q;
                ptr_d   = ptr_q + 11'h001;
                state_d = S_IDLE;
                if (ptr_q == `ELR_LOG_LAST) begin
                    full_d = 1'b1;
                end
            end
            S_CLEAR: begin
                memWe = 1'b1;
                ptr_d = ptr_q + 11'h001;
                if (ptr_q == `ELR_LOG_LAST) begin
                    memClr_d = 1'b1;
                    state_d  = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase

        if (startNow) begin
            me_d     = 1'b1;
            mip_d    = 1'b1;
            stamp_d  = rtcNow;
            ev0_d    = 16'h0000;
            count_d  = count_q + 24'h000001;
            etc_d    = {15'h0000, tick};
            memClr_d = 1'b0;
        end

        // a new edge in the consuming cycle wins over the clear of the pending flag
        evPend_d = (evPend_q & ~consume) | (evEdge & mip_q);
        if (!mip_d) begin
            evPend_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q    <= S_IDLE;
            me_q       <= 1'b0;
            mip_q      <= 1'b0;
            memClr_q   <= 1'b0;
            rof_q      <= 1'b0;
            full_q     <= 1'b0;
            stopPend_q <= 1'b0;
            evPend_q   <= 1'b0;
            trig_q     <= 2'(`ELR_CTRL_RST >> `ELR_CTRL_TRIG_LSB);
            dis_q      <= `ELR_DIS_OFF;
            wrap_q     <= 1'b0;
            stamp_q    <= 64'h0;
            ev0_q      <= 16'h0000;
            count_q    <= 24'h000000;
            etc_q      <= 16'h0000;
            ptr_q      <= 11'h000;
            hiByte_q   <= 8'h00;
            logAdr_q   <= 16'h0000;
            mainPtr_q  <= 8'h00;
            rdData_q   <= 8'h00;
            ackTgl_q   <= 1'b0;
            evS1_q     <= 1'b0;
            evS2_q     <= 1'b0;
            evPrev_q   <= 1'b0;
            reqS1_q    <= 1'b0;
            reqS2_q    <= 1'b0;
            reqS3_q    <= 1'b0;
        end else begin
            state_q    <= state_d;
            me_q       <= me_d;
            mip_q      <= mip_d;
            memClr_q   <= memClr_d;
            rof_q      <= rof_d;
            full_q     <= full_d;
            stopPend_q <= stopPend_d;
            evPend_q   <= evPend_d;
            trig_q     <= trig_d;
            dis_q      <= dis_d;
            wrap_q     <= wrap_d;
            stamp_q    <= stamp_d;
            ev0_q      <= ev0_d;
            count_q    <= count_d;
            etc_q      <= etc_d;
            ptr_q      <= ptr_d;
            hiByte_q   <= hiByte_d;
            logAdr_q   <= logAdr_d;
            mainPtr_q  <= mainPtr_d;
            rdData_q   <= rdData_d;
            ackTgl_q   <= ackTgl_d;
            evS1_q     <= evS1_d;
            evS2_q     <= evS2_d;
            evPrev_q   <= evPrev_d;
            reqS1_q    <= reqS1_d;
            reqS2_q    <= reqS2_d;
            reqS3_q    <= reqS3_d;
        end
    end

    // only the recorder writes the log; the host path has no write port into it
    always_ff @(posedge clk) begin
        if (memWe) begin
            logMem[memAddr] <= memWd;
        end
    end

    // link side: one request in flight, toggle handshake both ways
    always_comb begin
        lrS1_d   = rst;
        lrS2_d   = lrS1_q;
        ackS1_d  = ackTgl_q;
        ackS2_d  = ackS1_q;
        ackS3_d  = ackS2_q;
        busy_d   = busy_q;
        reqTgl_d = reqTgl_q;
        hold_d   = hold_q;
        rspV_d   = 1'b0;
        rspD_d   = rspD_q;
        if (hostReqValid && !busy_q) begin
            hold_d   = hostReq;
            reqTgl_d = ~reqTgl_q;
            busy_d   = 1'b1;
        end
        if (busy_q && (ackS2_q ^ ackS3_q)) begin
            busy_d = 1'b0;
            rspV_d = 1'b1;
            rspD_d = rdData_q;
        end
    end

    always_ff @(posedge linkClk) begin
        lrS1_q <= lrS1_d;
        lrS2_q <= lrS2_d;
        if (lrS2_q) begin
            ackS1_q  <= 1'b0;
            ackS2_q  <= 1'b0;
            ackS3_q  <= 1'b0;
            busy_q   <= 1'b0;
            reqTgl_q <= 1'b0;
            hold_q   <= '0;
            rspV_q   <= 1'b0;
            rspD_q   <= 8'h00;
        end else begin
            ackS1_q  <= ackS1_d;
            ackS2_q  <= ackS2_d;
            ackS3_q  <= ackS3_d;
            busy_q   <= busy_d;
            reqTgl_q <= reqTgl_d;
            hold_q   <= hold_d;
            rspV_q   <= rspV_d;
            rspD_q   <= rspD_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_start_trig_valid: assert property ($rose(mip_q) |-> $past(trig_q) != 2'b00)
        else $error("mission started with no trigger edge selected");
    a_start_needs_clear: assert property ($rose(mip_q) |-> $past(memClr_q) && !memClr_q)
        else $error("mission started without a cleared memory");
    a_start_effects: assert property ($rose(mip_q) |-> me_q && ev0_q == 16'h0000 &&
        stamp_q == $past(rtcNow) && count_q == $past(count_q) + 24'h000001)
        else $error("mission start did not stamp, zero and count");
    a_store_two_bytes: assert property ((state_q == S_IDLE && memWe && mip_q) |=>
        (state_q == S_HI && memWe && memAddr == $past(ptr_q) + 11'h001) ##1 state_q == S_IDLE)
        else $error("event store did not write two consecutive bytes");
    a_stop_after_store: assert property ((state_q == S_HI) |-> mip_q && me_q)
        else $error("mission flags dropped while an event was being stored");
    a_write_stops: assert property ((reqNew && hold_q.wr && mip_q && state_q == S_IDLE && !evPend_q)
        |=> ##[0:4] !mip_q)
        else $error("host write did not end the mission");
    a_read_gated: assert property ((reqNew && mip_q && reqAddr > 8'h2f) |=> rdData_q == 8'h00)
        else $error("read above user area returned data during a mission");
    a_wrap_sticky: assert property ((rof_q && !clrStart) |=> rof_q)
        else $error("wrap flag cleared without a memory clear");
    a_full_no_log: assert property ((full_q && state_q != S_CLEAR) |-> !memWe)
        else $error("log written while full");
    a_full_counts: assert property ((consume && full_q) |=> count_q == $past(count_q) + 24'h000001)
        else $error("event not counted with a full log");
    a_etc_restart: assert property (consume |=> etc_q <= 16'h0001)
        else $error("elapsed counter not restarted after an event");
    a_link_answer: assert property (@(posedge linkClk) disable iff (lrS2_q)
        (hostReqValid && hostReqReady) |-> ##[2:12] hostRspValid)
        else $error("host request not answered in time");

    c_host_start: cover property (reqNew && hold_q.wr && reqAddr == `ELR_A_STAT && startNow);
    c_armed_start: cover property (me_q && !mip_q && evEdge);
    c_wrap: cover property ($rose(rof_q));
    c_stop: cover property ($fell(mip_q));

endmodule : elr_event_log_mission_recorder

// *** hw/elr_regs.svh ***
// register offsets, field positions, encodings and reset values of the event log recorder
`ifndef ELR_REGS_SVH
`define ELR_REGS_SVH

`define ELR_A_RTC_TOP      8'h07
`define ELR_A_CTRL         8'h0e
`define ELR_A_STAT         8'h0f
`define ELR_A_USER_TOP     8'h2f
`define ELR_A_STAMP        8'h30
`define ELR_A_EV0_LO       8'h38
`define ELR_A_EV0_HI       8'h39
`define ELR_A_CNT_LO       8'h3a
`define ELR_A_CNT_MID      8'h3b
`define ELR_A_CNT_HI       8'h3c
`define ELR_A_ETC_LO       8'h3d
`define ELR_A_ETC_HI       8'h3e
`define ELR_A_PTR_LO       8'h3f
`define ELR_A_PTR_HI       8'h40
`define ELR_A_LADR_LO      8'h41
`define ELR_A_LADR_HI      8'h42
`define ELR_A_LDATA        8'h43

`define ELR_CTRL_ARM       7
`define ELR_CTRL_DIS_MSB   5
`define ELR_CTRL_DIS_LSB   4
`define ELR_CTRL_WRAP      3
`define ELR_CTRL_TRIG_MSB  2
`define ELR_CTRL_TRIG_LSB  1
`define ELR_STAT_MEMCLR    6
`define ELR_STAT_MIP       5
`define ELR_STAT_ROF       2

`define ELR_TRIG_NONE      2'b00
`define ELR_DIS_OFF        2'b00
`define ELR_DIS_SEC        2'b01
`define ELR_DIS_MIN        2'b10
`define ELR_DIS_HOUR       2'b11

`define ELR_LOG_LAST       11'h7ff
`define ELR_CTRL_RST       8'h00

`endif

// *** hw/elr_pkg.sv ***
// types shared by the event log recorder
package elr_pkg;

    typedef struct packed {
        logic       wr;
        logic       setPtr;
        logic [7:0] addr;
        logic [7:0] data;
    } elr_req_t;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_CLEAR = 2'b01,
        S_HI    = 2'b10
    } elr_state_t;

endpackage : elr_pkg

// *** tb/elr_host_model.sv ***
// host-side model of the byte port: one request at a time on its own clock
`timescale 1ns/1ps
module elr_host_model
    import elr_pkg::*;
(
    output logic             linkClk,
    output logic             hostReqValid,
    input  wire logic        hostReqReady,
    output elr_req_t         hostReq,
    input  wire logic        hostRspValid,
    input  wire logic [7:0]  hostRspData
);
    // phase offset keeps the port clock unrelated to the core clock
    initial begin
        linkClk = 1'b0;
        hostReqValid = 1'b0;
        hostReq = '0;
        #37;
        forever #80 linkClk = ~linkClk;
    end

    // request held until ready is seen, then released with a scrambled pattern
    task automatic access(input logic wr, input logic setPtr, input logic [7:0] addr,
                          input logic [7:0] data, output logic [7:0] rdData);
        int n;
        n = 0;
        @(posedge linkClk);
        hostReqValid <= 1'b1;
        hostReq <= {wr, setPtr, addr, data};
        @(negedge linkClk);
        while (hostReqReady !== 1'b1) @(negedge linkClk);
        @(posedge linkClk);
        hostReqValid <= 1'b0;
        hostReq <= ~hostReq;
        @(negedge linkClk);
        while (hostRspValid !== 1'b1 && n < 20) begin
            @(negedge linkClk);
            n++;
        end
        rdData = (n < 20) ? hostRspData : 8'hxx;
    endtask : access
endmodule : elr_host_model

// *** tb/testbench.sv ***
// self-checking bench for the event log mission recorder
`timescale 1ns/1ps
module testbench;
    logic             clk, rst, linkClk, eventIn, rtcSecInc, rtcMinInc, rtcHrInc, clearCmd;
    logic             hostReqValid, hostReqReady, hostRspValid;
    logic [63:0]      rtcNow;
    logic [7:0]       hostRspData, rd;
    elr_pkg::elr_req_t hostReq;
    int               err_total = 0, n_compared = 0, cycles = 0;

    elr_event_log_mission_recorder i_elr_event_log_mission_recorder (
        .clk(clk), .rst(rst), .linkClk(linkClk), .eventIn(eventIn), .rtcNow(rtcNow),
        .rtcSecInc(rtcSecInc), .rtcMinInc(rtcMinInc), .rtcHrInc(rtcHrInc), .clearCmd(clearCmd),
        .hostReqValid(hostReqValid), .hostReqReady(hostReqReady), .hostReq(hostReq),
        .hostRspValid(hostRspValid), .hostRspData(hostRspData));
    elr_host_model i_elr_host_model (
        .linkClk(linkClk), .hostReqValid(hostReqValid), .hostReqReady(hostReqReady),
        .hostReq(hostReq), .hostRspValid(hostRspValid), .hostRspData(hostRspData));

    always #20 clk = ~clk;

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            $display("BAD t=%0t run did not finish", $time);
            print_verdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // the port model returns all-unknown when its answer limit runs out
    task automatic acc(input logic w, input logic p, input logic [7:0] a, input logic [7:0] d);
        i_elr_host_model.access(w, p, a, d, rd);
        if (rd === 8'hxx) begin
            err_total++;
            $display("BAD t=%0t host port gave no answer", $time);
        end
    endtask : acc

    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, 1'b1, a, d);
    endtask : wr8

    task automatic rd8(input logic [7:0] a);
        acc(1'b0, 1'b1, a, 8'h00);
    endtask : rd8

    // high byte goes without a pointer load so it lands on the advanced location
    task automatic read_log(input logic [10:0] a);
        wr8(8'h41, a[7:0]);
        acc(1'b1, 1'b0, 8'h00, {5'h00, a[10:8]});
        rd8(8'h43);
    endtask : read_log

    task automatic test_refuse();
        rd8(8'h0f);
        chk(rd & 8'h40, 8'h40);
        wr8(8'h0e, 8'h10);
        wr8(8'h0f, 8'h20);
        rd8(8'h0f);
        chk(rd & 8'h20, 8'h00);
    endtask : test_refuse

    task automatic test_mission();
        wr8(8'h0e, 8'h14);
        wr8(8'h0f, 8'h20);
        rd8(8'h0f);
        chk(rd & 8'h20, 8'h20);
        rd8(8'h30);
        chk(rd, 8'h00);
        repeat (3) begin
            @(posedge clk) rtcSecInc <= 1'b1;
            @(posedge clk) rtcSecInc <= 1'b0;
            repeat (3) @(posedge clk);
        end
        @(posedge clk) eventIn <= 1'b1;
        repeat (20) @(posedge clk);
        wr8(8'h0f, 8'h00);
        repeat (10) @(posedge clk);
        rd8(8'h0f);
        chk(rd & 8'h20, 8'h00);
        rd8(8'h0e);
        chk(rd & 8'h80, 8'h00);
        rd8(8'h30);
        chk(rd, 8'h01);
        rd8(8'h3a);
        chk(rd, 8'h02);
        read_log(11'h000);
        chk(rd, 8'h03);
        read_log(11'h001);
        chk(rd, 8'h00);
        wr8(8'h43, 8'h55);
        read_log(11'h000);
        chk(rd, 8'h03);
        wr8(8'h0f, 8'h20);
        rd8(8'h0f);
        chk(rd & 8'h20, 8'h00);
    endtask : test_mission

    task automatic do_clear();
        @(posedge clk) clearCmd <= 1'b1;
        @(posedge clk) clearCmd <= 1'b0;
        repeat (2060) @(posedge clk);
    endtask : do_clear

    // unequal tick counts per unit so a wrong interval choice shows in the stored value
    task automatic toggle_ev(input int nSec, input int nMin, input int nHr);
        repeat (nSec) begin
            @(posedge clk) rtcSecInc <= 1'b1;
            @(posedge clk) rtcSecInc <= 1'b0;
        end
        repeat (nMin) begin
            @(posedge clk) rtcMinInc <= 1'b1;
            @(posedge clk) rtcMinInc <= 1'b0;
        end
        repeat (nHr) begin
            @(posedge clk) rtcHrInc <= 1'b1;
            @(posedge clk) rtcHrInc <= 1'b0;
        end
        @(posedge clk) eventIn <= ~eventIn;
        repeat (5) @(posedge clk);
    endtask : toggle_ev

    // armed start on both edges, minute units, 1024 stores fill the log, then two more events
    task automatic test_fill(input logic wrapOn);
        @(posedge clk) rtcNow <= 64'h0807060504030201;
        do_clear();
        wr8(8'h0e, {4'ha, wrapOn, 3'b110});
        rd8(8'h0f);
        chk(rd & 8'h60, 8'h40);
        rd8(8'h0e);
        chk(rd, {4'ha, wrapOn, 3'b110});
        toggle_ev(0, 0, 0);
        rd8(8'h0f);
        chk(rd & 8'h20, 8'h20);
        toggle_ev(1, 2, 1);
        repeat (1023) toggle_ev(0, 0, 0);
        @(posedge clk) rtcNow <= 64'h1817161514131211;
        toggle_ev(1, 3, 1);
        toggle_ev(1, 4, 1);
        wr8(8'h0f, 8'h00);
        repeat (10) @(posedge clk);
        rd8(8'h0f);
        chk(rd & 8'h64, {5'h00, wrapOn, 2'b00});
        rd8(8'h30);
        chk(rd, wrapOn ? 8'h11 : 8'h01);
        rd8(8'h38);
        chk(rd, wrapOn ? 8'h03 : 8'h00);
        rd8(8'h3a);
        chk(rd, 8'h03);
        rd8(8'h3b);
        chk(rd, 8'h04);
        rd8(8'h3f);
        chk(rd, wrapOn ? 8'h02 : 8'h00);
        read_log(11'h000);
        chk(rd, wrapOn ? 8'h04 : 8'h02);
    endtask : test_fill

    // falling edges only, hour units: the rising edge in between must not count
    task automatic test_falling();
        @(posedge clk) eventIn <= 1'b1;
        do_clear();
        wr8(8'h0e, 8'hb2);
        toggle_ev(0, 0, 0);
        toggle_ev(1, 1, 1);
        toggle_ev(1, 1, 2);
        wr8(8'h0f, 8'h00);
        repeat (10) @(posedge clk);
        rd8(8'h3a);
        chk(rd, 8'h02);
        read_log(11'h000);
        chk(rd, 8'h03);
    endtask : test_falling

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        eventIn = 1'b0;
        rtcSecInc = 1'b0;
        rtcMinInc = 1'b0;
        rtcHrInc = 1'b0;
        clearCmd = 1'b0;
        rtcNow = 64'h0807060504030201;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (20) @(posedge clk);
        do_clear();
        test_refuse();
        test_mission();
        test_fill(1'b0);
        test_fill(1'b1);
        test_falling();
        print_verdict();
    end
endmodule : testbench
